// ### dv/cod_fetch_model.sv
/*
  cod_fetch_model: program memory fetch side offering opcode bytes.
  Assumes the bench calls offer; lines move only on falling clock edges.
*/
`timescale 1ns/100ps
module cod_fetch_model (
  input wire logic sys_clk,
  input wire logic op_ready,
  output logic op_valid,
  output logic [7:0] opcode,
  output logic [3:0] extended_opcode_select
);
  initial begin
    op_valid = 1'b0;
    opcode = 8'h00;
    extended_opcode_select = 4'h0;
  end
  // held until taken; idle lines show the inverse so stale bytes never match
  task automatic offer(input logic [7:0] b, input logic [3:0] eos);
    @(negedge sys_clk);
    op_valid = 1'b1;
    opcode = b;
    extended_opcode_select = eos;
    while (op_ready !== 1'b1) @(negedge sys_clk);
    @(posedge sys_clk);
    @(negedge sys_clk);
    op_valid = 1'b0;
    opcode = ~b;
    extended_opcode_select = ~eos;
  endtask
endmodule

// ### dv/cod_opcode_decoder_asserts.sv
/*
  cod_opcode_decoder_asserts: timing and field checks on the decoder ports.
  Assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/100ps
module cod_opcode_decoder_asserts
  import cod_pkg::*;
#(
  parameter int CLKS_MC = CLKS_PER_MC
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic op_valid,
  input wire logic [7:0] opcode,
  input wire logic op_ready,
  input wire logic info_valid,
  input wire logic [2:0] instr_cycles,
  input wire logic [2:0] work_reg,
  input wire logic work_reg_valid,
  input wire logic ind_reg,
  input wire logic ind_reg_valid,
  input wire logic [2:0] page_addr_hi,
  input wire logic page_addr_valid,
  input wire logic clear_tested_bit,
  input wire logic mc_tick,
  input wire logic instr_done
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic take;
  int cnt;
  assign take = op_valid && op_ready;
  // clocks since the taking edge, so pulse timing is judged in one place
  always_ff @(posedge sys_clk) begin
    if (sys_rst) cnt <= 0;
    else if (take) cnt <= 1;
    else cnt <= cnt + 1;
  end
  info_after_take_a: assert property (take |=> info_valid && !op_ready)
    else $error("decode not shown after opcode taken");
  four_cycle_ops_a: assert property (take |=>
    (instr_cycles == CYC_4) ==
    ($past(opcode) == 8'ha4 || $past(opcode) == 8'h84))
    else $error("four cycle count on wrong opcode");
  reg_field_a: assert property (take && opcode[3] |=>
    work_reg_valid && work_reg == $past(opcode[2:0]))
    else $error("register number not from low opcode bits");
  page_bits_a: assert property (take && opcode[3:0] == 4'h1 |=>
    page_addr_valid && page_addr_hi == $past(opcode[7:5]))
    else $error("page address bits wrong");
  ind_pair_a: assert property (take && opcode[3:1] == 3'b011 |=>
    ind_reg_valid && ind_reg == $past(opcode[0]))
    else $error("indirect register select wrong");
  done_time_a: assert property (instr_done |->
    cnt == CLKS_MC * int'(instr_cycles))
    else $error("instruction end at wrong clock");
  tick_period_a: assert property (mc_tick |-> cnt % CLKS_MC == 0)
    else $error("machine cycle tick off its period");
  done_on_tick_a: assert property (instr_done |-> mc_tick)
    else $error("instruction end without tick");
  clear_bit_a: assert property (take |=>
    clear_tested_bit == ($past(opcode) == 8'h10))
    else $error("bit clear flag wrong");
  idle_after_a: assert property (instr_done |=> op_ready && !info_valid)
    else $error("decoder not idle after end");
  cover property (take && opcode == 8'ha4);
  cover property (take && opcode[3:0] == 4'h1);
  cover property (instr_done ##1 take);
endmodule
bind cod_opcode_decoder cod_opcode_decoder_asserts #(.CLKS_MC(CLKS_MC))
  i_asserts (.sys_clk(sys_clk), .sys_rst(sys_rst), .op_valid(op_valid),
  .opcode(opcode), .op_ready(op_ready), .info_valid(info_valid),
  .instr_cycles(instr_cycles), .work_reg(work_reg),
  .work_reg_valid(work_reg_valid), .ind_reg(ind_reg),
  .ind_reg_valid(ind_reg_valid), .page_addr_hi(page_addr_hi),
  .page_addr_valid(page_addr_valid), .clear_tested_bit(clear_tested_bit),
  .mc_tick(mc_tick), .instr_done(instr_done));

// ### dv/cod_opcode_decoder_bench.sv
/*
  cod_opcode_decoder_bench: self-checking bench of the opcode decoder.
  Assumes the fetch model drives requests and the checker is bound in.
*/
`timescale 1ns/100ps
module cod_opcode_decoder_bench;
  import cod_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic op_valid, op_ready, info_valid, work_reg_valid, ind_reg, ind_reg_valid;
  logic page_addr_valid, clear_tested_bit, mc_tick, instr_done;
  logic [7:0] opcode;
  logic [3:0] eos;
  logic [1:0] instr_len;
  logic [2:0] instr_cycles, work_reg, page_addr_hi;
  cod_class_t instr_class;
  int error_cnt = 0;
  int tests_run = 0;
  always #5 sys_clk = ~sys_clk;
  cod_fetch_model i_fetch (.sys_clk(sys_clk), .op_ready(op_ready),
    .op_valid(op_valid), .opcode(opcode), .extended_opcode_select(eos));
  cod_opcode_decoder #(.CLKS_MC(CLKS_PER_MC)) i_dut (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .op_valid(op_valid), .opcode(opcode),
    .extended_opcode_select(eos), .op_ready(op_ready),
    .info_valid(info_valid), .instr_len(instr_len),
    .instr_cycles(instr_cycles), .instr_class(instr_class),
    .work_reg(work_reg), .work_reg_valid(work_reg_valid), .ind_reg(ind_reg),
    .ind_reg_valid(ind_reg_valid), .page_addr_hi(page_addr_hi),
    .page_addr_valid(page_addr_valid), .clear_tested_bit(clear_tested_bit),
    .mc_tick(mc_tick), .instr_done(instr_done));
  task automatic test_done();
    $display("errors %0d of %0d checks", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk_vec(logic [7:0] got, logic [7:0] exp, string what);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_cls(cod_class_t got, cod_class_t exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t class got %h exp %h", $time, got, exp);
    end
  endtask
  // one instruction: decode one clock on, end after two clocks per cycle
  task automatic op(logic [7:0] b, logic [1:0] len, logic [2:0] cyc,
                    cod_class_t cls, logic [3:0] e = 4'h0);
    int n;
    i_fetch.offer(b, e);
    n = 1;
    chk_vec(8'(info_valid), 8'h01, "info valid");
    chk_vec(8'(instr_len), 8'(len), "length");
    chk_vec(8'(instr_cycles), 8'(cyc), "cycles");
    chk_cls(instr_class, cls);
    chk_vec(8'(work_reg_valid), 8'(b[3]), "reg valid");
    if (b[3]) chk_vec(8'(work_reg), 8'(b[2:0]), "register");
    chk_vec(8'(page_addr_valid), 8'(b[3:0] == 4'h1), "page valid");
    if (b[3:0] == 4'h1) chk_vec(8'(page_addr_hi), 8'(b[7:5]), "page");
    chk_vec(8'(clear_tested_bit), 8'(b == 8'h10), "bit clear");
    chk_vec(8'(ind_reg_valid), 8'(b[3:1] == 3'h3 ||
      (b[7:5] == 3'h7 && b[3:1] == 3'h1)), "indirect valid");
    if (b[3:1] == 3'h3) chk_vec(8'(ind_reg), 8'(b[0]), "indirect");
    while (instr_done !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    chk_vec(8'(n), 8'(CLKS_PER_MC * cyc), "clocks to end");
  endtask
  task automatic s_arith();
    op(8'h28, LEN_1, CYC_1, CL_ARITH);
    op(8'h35, LEN_2, CYC_1, CL_ARITH);
    op(8'h97, LEN_1, CYC_1, CL_ARITH);
    op(8'h94, LEN_2, CYC_1, CL_ARITH);
    op(8'h3f, LEN_1, CYC_1, CL_ARITH);
    op(8'ha4, LEN_1, CYC_4, CL_MULDIV);
    op(8'h84, LEN_1, CYC_4, CL_MULDIV);
  endtask
  task automatic s_logic();
    op(8'h53, LEN_3, CYC_2, CL_LOGIC);
    op(8'h43, LEN_3, CYC_2, CL_LOGIC);
    op(8'h63, LEN_3, CYC_2, CL_LOGIC);
    op(8'h5f, LEN_1, CYC_1, CL_LOGIC);
    op(8'h48, LEN_1, CYC_1, CL_LOGIC);
    op(8'h6b, LEN_1, CYC_1, CL_LOGIC);
    op(8'hc4, LEN_1, CYC_1, CL_ACC_UNARY);
    op(8'h33, LEN_1, CYC_1, CL_ACC_UNARY);
    op(8'h13, LEN_1, CYC_1, CL_ACC_UNARY);
  endtask
  task automatic s_moves();
    op(8'h93, LEN_1, CYC_2, CL_CODE_READ);
    op(8'h83, LEN_1, CYC_2, CL_CODE_READ);
    op(8'he0, LEN_1, CYC_2, CL_XDATA);
    op(8'hf3, LEN_1, CYC_2, CL_XDATA);
    op(8'h85, LEN_3, CYC_2, CL_MOVE);
    op(8'h90, LEN_3, CYC_2, CL_MOVE);
    op(8'hd0, LEN_2, CYC_2, CL_STACK);
    op(8'hcd, LEN_1, CYC_1, CL_EXCH);
    op(8'hd7, LEN_1, CYC_1, CL_NIBBLE_EXCH);
  endtask
  task automatic s_bool();
    op(8'h82, LEN_2, CYC_2, CL_BOOL);
    op(8'ha0, LEN_2, CYC_2, CL_BOOL);
    op(8'ha2, LEN_2, CYC_1, CL_BOOL);
    op(8'h92, LEN_2, CYC_2, CL_BOOL);
  endtask
  task automatic s_branch();
    op(8'h12, LEN_3, CYC_2, CL_CALL);
    op(8'h32, LEN_1, CYC_2, CL_RETURN);
    op(8'h80, LEN_2, CYC_2, CL_JUMP);
    op(8'h70, LEN_2, CYC_2, CL_COND_BRANCH);
    op(8'h10, LEN_3, CYC_2, CL_COND_BRANCH);
    op(8'hb5, LEN_3, CYC_2, CL_COND_BRANCH);
    op(8'hdf, LEN_3, CYC_2, CL_COND_BRANCH);
    op(8'h73, LEN_1, CYC_2, CL_JUMP);
    op(8'h00, LEN_1, CYC_1, CL_NOP);
    op(8'hf1, LEN_2, CYC_2, CL_CALL);
    op(8'he1, LEN_2, CYC_2, CL_JUMP);
  endtask
  task automatic s_extended();
    op(8'ha5, LEN_1, CYC_2, CL_CODE_STORE, EOS_CODE_STORE);
    op(8'ha5, LEN_1, CYC_1, CL_TRAP, EOS_TRAP);
    op(8'ha5, LEN_1, CYC_1, CL_ILLEGAL, 4'h0);
  endtask
  // reset in mid multiply must drop the instruction within two clocks
  task automatic s_reset();
    i_fetch.offer(8'ha4, 4'h0);
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk_vec(8'(op_ready), 8'h01, "ready in reset");
    chk_vec(8'(info_valid), 8'h00, "valid in reset");
    chk_vec(8'(instr_len), 8'(LEN_1), "length in reset");
    chk_vec(8'(instr_cycles), 8'(CYC_1), "cycles in reset");
    chk_cls(instr_class, CL_NOP);
    sys_rst = 1'b0;
    op(8'hea, LEN_1, CYC_1, CL_MOVE);
  endtask
  initial begin
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    s_arith();
    s_logic();
    s_moves();
    s_bool();
    s_branch();
    s_extended();
    s_reset();
    test_done();
  end
  // about 45 instructions of at most ten clocks each
  initial begin
    #50000;
    error_cnt++;
    test_done();
  end
endmodule

// ### pkg/cod_pkg.sv
/*
  cod_pkg: shared constants and types of the opcode decoder.
  Assumes one system clock at 100 MHz and a machine cycle of two clocks.
*/
package cod_pkg;

  // system clock and machine cycle timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLKS_PER_MC = 2;

  // instruction lengths in bytes
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;

  // execution times in machine cycles
  localparam logic [2:0] CYC_1 = 3'h1;
  localparam logic [2:0] CYC_2 = 3'h2;
  localparam logic [2:0] CYC_4 = 3'h4;

  // opcode nibble and byte codes; the decoder uses LO_PAGE and OP_JUMP_BIT_CLEAR
  localparam logic [3:0] LO_PAGE = 4'h1;
  localparam logic [3:0] LO_DIRECT = 4'h5;
  localparam logic [7:0] OP_EXTENDED = 8'ha5;
  localparam logic [7:0] OP_JUMP_BIT_CLEAR = 8'h10;

  // extended opcode select values picked for the two extra instructions
  localparam logic [3:0] EOS_CODE_STORE = 4'h1;
  localparam logic [3:0] EOS_TRAP = 4'h2;

  typedef enum logic [4:0] {
    CL_NOP = 5'h00,
    CL_ARITH = 5'h01,
    CL_LOGIC = 5'h02,
    CL_ACC_UNARY = 5'h03,
    CL_MULDIV = 5'h04,
    CL_MOVE = 5'h05,
    CL_CODE_READ = 5'h06,
    CL_XDATA = 5'h07,
    CL_STACK = 5'h08,
    CL_EXCH = 5'h09,
    CL_NIBBLE_EXCH = 5'h0a,
    CL_BOOL = 5'h0b,
    CL_JUMP = 5'h0c,
    CL_CALL = 5'h0d,
    CL_RETURN = 5'h0e,
    CL_COND_BRANCH = 5'h0f,
    CL_CODE_STORE = 5'h10,
    CL_TRAP = 5'h11,
    CL_ILLEGAL = 5'h12
  } cod_class_t;

  typedef struct packed {
    logic [1:0] len;
    logic [2:0] cyc;
    cod_class_t cls;
  } cod_dec_t;

  function automatic cod_dec_t cod_mk(input logic [1:0] len,
                                      input logic [2:0] cyc,
                                      input cod_class_t cls);
    cod_dec_t d;
    d.len = len;
    d.cyc = cyc;
    d.cls = cls;
    return d;
  endfunction

endpackage

// ### src/cod_mcycle_timer.sv
/*
  cod_mcycle_timer: divides the system clock into machine cycles.
  Assumes run is held high for the whole of an instruction's execution.
*/
`timescale 1ns/100ps
module cod_mcycle_timer
  import cod_pkg::*;
#(
  parameter int CLKS = CLKS_PER_MC
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic run,
  output logic mc_tick
);

  generate
    if (CLKS < 2 || CLKS > 16) begin : g_bad_clks
      $error("machine cycle length out of range");
    end
  endgenerate

  typedef struct packed {
    logic [3:0] count;
  } cod_tmr_state_t;

  localparam logic [3:0] LAST = 4'(CLKS - 1);

  cod_tmr_state_t st;
  cod_tmr_state_t next_st;

  // tick marks the last clock of each machine cycle
  assign mc_tick = run && (st.count == LAST);

  always_comb begin
    next_st = st;
    if (!run || mc_tick) begin
      next_st.count = 4'h0;
    end else begin
      next_st.count = st.count + 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

// ### src/cod_opcode_decoder.sv
/*
  cod_opcode_decoder: opcode decoder and machine cycle sequencer of an
  8-bit core. Takes one opcode byte, reports length, machine cycles,
  operation class and fields embedded in the opcode, then counts the
  instruction's machine cycles.
  Assumes the fetch unit offers opcode with op_valid on sys_clk and that
  extended_opcode_select comes from a register on the same clock.
*/
// Behaviour
// - every opcode reports one to three bytes
// - one, two or four cycles; only mul/div four
// - machine cycle lasts two system clocks
// - register blocks take register from low bits
// - page jumps use top opcode bits as address
// - add forms in four modes, one cycle
// - logic immediate to direct: three bytes, two cycles
// - register logic into accumulator: one byte, cycle
// - accumulator unary ops are one byte, cycle
// - code reads are one byte, two cycles
// - external moves one byte, two cycles
// - direct-direct move, pointer load: three bytes, two
// - push and pop: two bytes, two cycles
// - byte exchanges, nibble exchange in one cycle
// - bit logic into carry: two bytes, two
// - bit to carry one cycle, back two
// - long call, returns take two cycles
// - relative and flag jumps: two bytes, two
// - bit jumps three bytes; clear variant clears bit
// - compare and decrement jumps three bytes, two
// - indirect jump two cycles; no-op one cycle
// - extended opcode picks code store or trap
`timescale 1ns/100ps
module cod_opcode_decoder
  import cod_pkg::*;
#(
  parameter int CLKS_MC = CLKS_PER_MC
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic op_valid,
  input wire logic [7:0] opcode,
  input wire logic [3:0] extended_opcode_select,
  output logic op_ready,
  output logic info_valid,
  output logic [1:0] instr_len,
  output logic [2:0] instr_cycles,
  output cod_class_t instr_class,
  output logic [2:0] work_reg,
  output logic work_reg_valid,
  output logic ind_reg,
  output logic ind_reg_valid,
  output logic [2:0] page_addr_hi,
  output logic page_addr_valid,
  output logic clear_tested_bit,
  output logic mc_tick,
  output logic instr_done
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } cod_fsm_t;

  typedef struct packed {
    cod_fsm_t fsm;
    logic [1:0] len;
    logic [2:0] cyc;
    cod_class_t cls;
    logic [2:0] work_reg;
    logic work_reg_valid;
    logic ind_reg;
    logic ind_reg_valid;
    logic [2:0] page_hi;
    logic page_valid;
    logic clr_bit;
    logic [2:0] mc_count;
  } cod_state_t;

  cod_state_t st;
  cod_state_t next_st;
  logic tick;
  logic last_mc;

  // full opcode map, split on the low nibble then the high nibble
  function automatic cod_dec_t cod_decode(input logic [7:0] op,
                                          input logic [3:0] eos);
    cod_dec_t d;
    logic [3:0] hi;
    logic [3:0] lo;
    d = cod_mk(LEN_1, CYC_1, CL_ILLEGAL);
    hi = op[7:4];
    lo = op[3:0];
    if (lo[3] || lo[3:1] == 3'h3) begin
      // register (x8-xF) and indirect (x6-x7) blocks share one map
      unique case (hi)
        4'h0, 4'h1: d = cod_mk(LEN_1, CYC_1, CL_ARITH);
        4'h2, 4'h3, 4'h9: d = cod_mk(LEN_1, CYC_1, CL_ARITH);
        4'h4, 4'h5, 4'h6: d = cod_mk(LEN_1, CYC_1, CL_LOGIC);
        4'h7: d = cod_mk(LEN_2, CYC_1, CL_MOVE);
        4'h8, 4'ha: d = cod_mk(LEN_2, CYC_2, CL_MOVE);
        4'hb: d = cod_mk(LEN_3, CYC_2, CL_COND_BRANCH);
        4'hc: d = cod_mk(LEN_1, CYC_1, CL_EXCH);
        4'hd: begin
          if (lo[3]) begin
            d = cod_mk(LEN_3, CYC_2, CL_COND_BRANCH);
          end else begin
            d = cod_mk(LEN_1, CYC_1, CL_NIBBLE_EXCH);
          end
        end
        4'he, 4'hf: d = cod_mk(LEN_1, CYC_1, CL_MOVE);
      endcase
    end else begin
      unique case (lo)
        4'h0: begin
          unique case (hi)
            4'h0: d = cod_mk(LEN_1, CYC_1, CL_NOP);
            4'h1, 4'h2, 4'h3: d = cod_mk(LEN_3, CYC_2, CL_COND_BRANCH);
            4'h4, 4'h5, 4'h6, 4'h7:
              d = cod_mk(LEN_2, CYC_2, CL_COND_BRANCH);
            4'h8: d = cod_mk(LEN_2, CYC_2, CL_JUMP);
            4'h9: d = cod_mk(LEN_3, CYC_2, CL_MOVE);
            4'ha, 4'hb: d = cod_mk(LEN_2, CYC_2, CL_BOOL);
            4'hc, 4'hd: d = cod_mk(LEN_2, CYC_2, CL_STACK);
            4'he, 4'hf: d = cod_mk(LEN_1, CYC_2, CL_XDATA);
          endcase
        end
        4'h1: begin
          if (hi[0]) begin
            d = cod_mk(LEN_2, CYC_2, CL_CALL);
          end else begin
            d = cod_mk(LEN_2, CYC_2, CL_JUMP);
          end
        end
        4'h2: begin
          unique case (hi)
            4'h0: d = cod_mk(LEN_3, CYC_2, CL_JUMP);
            4'h1: d = cod_mk(LEN_3, CYC_2, CL_CALL);
            4'h2, 4'h3: d = cod_mk(LEN_1, CYC_2, CL_RETURN);
            4'h4, 4'h5, 4'h6: d = cod_mk(LEN_2, CYC_1, CL_LOGIC);
            4'h7, 4'h8: d = cod_mk(LEN_2, CYC_2, CL_BOOL);
            4'h9: d = cod_mk(LEN_2, CYC_2, CL_BOOL);
            4'ha: d = cod_mk(LEN_2, CYC_1, CL_BOOL);
            4'hb, 4'hc, 4'hd: d = cod_mk(LEN_2, CYC_1, CL_BOOL);
            4'he, 4'hf: d = cod_mk(LEN_1, CYC_2, CL_XDATA);
          endcase
        end
        4'h3: begin
          unique case (hi)
            4'h0, 4'h1, 4'h2, 4'h3:
              d = cod_mk(LEN_1, CYC_1, CL_ACC_UNARY);
            4'h4, 4'h5, 4'h6: d = cod_mk(LEN_3, CYC_2, CL_LOGIC);
            4'h7: d = cod_mk(LEN_1, CYC_2, CL_JUMP);
            4'h8, 4'h9: d = cod_mk(LEN_1, CYC_2, CL_CODE_READ);
            4'ha: d = cod_mk(LEN_1, CYC_2, CL_ARITH);
            4'hb, 4'hc, 4'hd: d = cod_mk(LEN_1, CYC_1, CL_BOOL);
            4'he, 4'hf: d = cod_mk(LEN_1, CYC_2, CL_XDATA);
          endcase
        end
        4'h4: begin
          unique case (hi)
            4'h0, 4'h1, 4'hd: d = cod_mk(LEN_1, CYC_1, CL_ARITH);
            4'h2, 4'h3, 4'h9: d = cod_mk(LEN_2, CYC_1, CL_ARITH);
            4'h4, 4'h5, 4'h6: d = cod_mk(LEN_2, CYC_1, CL_LOGIC);
            4'h7: d = cod_mk(LEN_2, CYC_1, CL_MOVE);
            4'h8, 4'ha: d = cod_mk(LEN_1, CYC_4, CL_MULDIV);
            4'hb: d = cod_mk(LEN_3, CYC_2, CL_COND_BRANCH);
            4'hc, 4'he, 4'hf:
              d = cod_mk(LEN_1, CYC_1, CL_ACC_UNARY);
          endcase
        end
        4'h5: begin
          unique case (hi)
            4'h0, 4'h1: d = cod_mk(LEN_2, CYC_1, CL_ARITH);
            4'h2, 4'h3, 4'h9: d = cod_mk(LEN_2, CYC_1, CL_ARITH);
            4'h4, 4'h5, 4'h6: d = cod_mk(LEN_2, CYC_1, CL_LOGIC);
            4'h7, 4'h8: d = cod_mk(LEN_3, CYC_2, CL_MOVE);
            4'ha: begin
              if (eos == EOS_CODE_STORE) begin
                d = cod_mk(LEN_1, CYC_2, CL_CODE_STORE);
              end else if (eos == EOS_TRAP) begin
                d = cod_mk(LEN_1, CYC_1, CL_TRAP);
              end else begin
                // unselected extended opcode: flagged, one short cycle
                d = cod_mk(LEN_1, CYC_1, CL_ILLEGAL);
              end
            end
            4'hb, 4'hd: d = cod_mk(LEN_3, CYC_2, CL_COND_BRANCH);
            4'hc: d = cod_mk(LEN_2, CYC_1, CL_EXCH);
            4'he, 4'hf: d = cod_mk(LEN_2, CYC_1, CL_MOVE);
          endcase
        end
        default: d = cod_mk(LEN_1, CYC_1, CL_ILLEGAL);
      endcase
    end
    return d;
  endfunction

  // indirect register pairs: x6-x7 and the byte-wide external moves
  function automatic logic cod_is_indirect(input logic [7:0] op);
    logic r;
    r = (!op[3] && op[2:1] == 2'h3);
    if (op[7:5] == 3'h7 && op[3:1] == 3'h1) begin
      r = 1'b1;
    end
    return r;
  endfunction

  cod_mcycle_timer #(
    .CLKS(CLKS_MC)
  ) u_timer (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .run(st.fsm == ST_EXEC),
    .mc_tick(tick)
  );

  assign last_mc = (st.mc_count == 3'(st.cyc - 3'h1));

  always_comb begin
    cod_dec_t d;
    d = cod_decode(opcode, extended_opcode_select);
    next_st = st;
    unique case (st.fsm)
      ST_IDLE: begin
        if (op_valid) begin
          // decode lands in the first clock of the first machine cycle
          next_st.fsm = ST_EXEC;
          next_st.len = d.len;
          next_st.cyc = d.cyc;
          next_st.cls = d.cls;
          next_st.work_reg = opcode[2:0];
          next_st.work_reg_valid = opcode[3];
          next_st.ind_reg = opcode[0];
          next_st.ind_reg_valid = cod_is_indirect(opcode);
          next_st.page_hi = opcode[7:5];
          next_st.page_valid = (opcode[3:0] == LO_PAGE);
          next_st.clr_bit = (opcode == OP_JUMP_BIT_CLEAR);
          next_st.mc_count = 3'h0;
        end
      end
      ST_EXEC: begin
        if (tick) begin
          if (last_mc) begin
            next_st.fsm = ST_IDLE;
            next_st.mc_count = 3'h0;
          end else begin
            next_st.mc_count = st.mc_count + 3'h1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st <= '{fsm: ST_IDLE, len: LEN_1, cyc: CYC_1, cls: CL_NOP,
              default: '0};
    end else begin
      st <= next_st;
    end
  end

  // one idle clock between instructions keeps the handshake simple
  assign op_ready = (st.fsm == ST_IDLE);
  assign info_valid = (st.fsm == ST_EXEC);
  assign instr_len = st.len;
  assign instr_cycles = st.cyc;
  assign instr_class = st.cls;
  assign work_reg = st.work_reg;
  assign work_reg_valid = st.work_reg_valid;
  assign ind_reg = st.ind_reg;
  assign ind_reg_valid = st.ind_reg_valid;
  assign page_addr_hi = st.page_hi;
  assign page_addr_valid = st.page_valid;
  assign clear_tested_bit = st.clr_bit;
  assign mc_tick = tick;
  assign instr_done = tick && last_mc && (st.fsm == ST_EXEC);

endmodule
